// ===== hw/motion_event_pkg.sv
// constants for the motion-event register block: offsets, fields, timing.
// assumes a byte-wide register port driven by the serial interface logic.
package motion_event_pkg;
    localparam logic [7:0] ADDR_WAKE_UP_THS = 8'h34;
    localparam logic [7:0] ADDR_WAKE_SLEEP_ENTRY_TIME = 8'h35;
    localparam logic [7:0] ADDR_FREEFALL_CFG = 8'h36;
    localparam logic [7:0] ADDR_STATUS_COPY = 8'h37;
    localparam logic [7:0] ADDR_WAKEUP_SRC = 8'h38;
    localparam logic [7:0] ADDR_ORIENT_SRC = 8'h3a;
    localparam logic [7:0] ADDR_IRQ_SRC = 8'h3b;
    localparam logic [7:0] RESET_CFG = 8'h00;
    // wake_sleep_duration fields
    localparam int FF_TOP_BIT = 7;
    localparam int WAKE_TIME_LSB = 5;
    localparam int STATIONARY_BIT = 4;
    localparam int SLEEP_TIME_LSB = 0;
    // freefall_config fields
    localparam int FF_LOW_LSB = 3;
    localparam int FF_LIMIT_LSB = 0;
    // wake threshold register fields
    localparam int SLEEP_ON_BIT = 6;
    localparam int WAKE_LIMIT_LSB = 0;
    localparam logic [11:0] SLEEP_PERIODS_PER_COUNT = 12'h200;
    localparam logic [11:0] SLEEP_PERIODS_ZERO = 12'h010;
    localparam logic [15:0] ONE_16 = 16'h0001;
    localparam logic [5:0] ONE_6 = 6'h01;
    localparam logic [2:0] ONE_3 = 3'h1;
    localparam logic [1:0] ONE_2 = 2'h1;

    typedef enum logic [2:0] {
        SLP_AWAKE = 3'b001,
        SLP_COUNTING = 3'b010,
        SLP_ASLEEP = 3'b100
    } sleep_state_t;
endpackage : motion_event_pkg

// ===== hw/ff_threshold_rom.sv
// free-fall threshold decode table at the 2 g scale, registered output.
// assumes code changes are rare; one cycle of latency is harmless.
`timescale 1ns/1ps
module ff_threshold_rom (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // lookup
    input wire logic [2:0] i_code,
    output logic [4:0] o_lsb
);
    logic [4:0] lsb_d;
    logic [4:0] lsb_q;

    always_comb begin
        case (i_code)
            3'h0: lsb_d = 5'h05;
            3'h1: lsb_d = 5'h07;
            3'h2: lsb_d = 5'h08;
            3'h3: lsb_d = 5'h0a;
            3'h4: lsb_d = 5'h0b;
            3'h5: lsb_d = 5'h0d;
            3'h6: lsb_d = 5'h0f;
            default: lsb_d = 5'h10;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            lsb_q <= 5'h05;
        end else begin
            lsb_q <= lsb_d;
        end
    end

    assign o_lsb = lsb_q;
endmodule : ff_threshold_rom

// ===== hw/motion_event_detect_regs.sv
// motion-event registers with a small detection engine behind them.
// assumes a byte register port from the serial interface, an output
// data rate strobe, and per-axis magnitudes already offset and filtered.
`timescale 1ns/1ps
module motion_event_detect_regs
    import motion_event_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // sample side
    input wire logic i_sample_tick,
    input wire logic [5:0] i_mag_x,
    input wire logic [5:0] i_mag_y,
    input wire logic [5:0] i_mag_z,
    input wire logic [4:0] i_mag_total,
    input wire logic [5:0] i_orient_over,
    input wire logic i_orient_change,
    input wire logic i_temp_new,
    input wire logic i_temp_read,
    input wire logic i_accel_new,
    input wire logic i_accel_read,
    input wire logic i_fifo_full,
    input wire logic i_fifo_overwrite,
    // status outputs
    output logic o_asleep,
    output logic o_stationary_mode,
    output logic o_event_pending
);
    function automatic logic wake_over(input logic [5:0] mag,
                                       input logic [5:0] ths);
        wake_over = mag > ths;
    endfunction : wake_over

    function automatic logic is_asleep(input sleep_state_t s);
        is_asleep = (s == SLP_ASLEEP);
    endfunction : is_asleep

    logic [7:0] dur_q, dur_d;
    logic [7:0] ff_q, ff_d;
    logic [7:0] wths_q, wths_d;
    logic [7:0] rdata_q, rdata_d;
    logic [5:0] ff_cnt_q, ff_cnt_d;
    logic [1:0] wk_cnt_q, wk_cnt_d;
    logic [15:0] sl_cnt_q, sl_cnt_d;
    sleep_state_t st_q, st_d;
    logic ff_flag_q, ff_flag_d;
    logic wu_flag_q, wu_flag_d;
    logic [2:0] axis_q, axis_d;
    logic or_flag_q, or_flag_d;
    logic slch_q, slch_d;
    logic [5:0] orient_q, orient_d;
    logic temp_q, temp_d;
    logic accel_q, accel_d;
    logic overrun_q, overrun_d;
    logic pend_q, pend_d;
    logic stat_q, stat_d;
    logic asleep_q, asleep_d;
    logic [4:0] ff_limit;
    logic [5:0] ff_time;
    logic [5:0] wake_limit;
    logic [1:0] wk_time;
    logic [3:0] sleep_code;
    logic [15:0] sleep_limit;
    logic [17:0] mag_all;
    wire logic [2:0] axis_hit;
    logic wake_now, ff_now, irq_clear, ff_event, wk_event;

    // the table output is registered, so a new code applies one clock late
    ff_threshold_rom u_ff_rom (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_code(ff_q[FF_LIMIT_LSB +: 3]),
        .o_lsb(ff_limit)
    );

    // one comparator per axis; bit 2 is x, bit 0 is z
    assign mag_all = {i_mag_x, i_mag_y, i_mag_z};
    for (genvar g = 0; g < 3; g++) begin : g_axis
        assign axis_hit[g] = wake_over(mag_all[6*g +: 6], wake_limit);
    end

    always_comb begin
        ff_time = {dur_q[FF_TOP_BIT], ff_q[FF_LOW_LSB +: 5]};
        wk_time = dur_q[WAKE_TIME_LSB +: 2];
        wake_limit = wths_q[WAKE_LIMIT_LSB +: 6];
        sleep_code = dur_q[SLEEP_TIME_LSB +: 4];
        if (sleep_code == 4'h0) begin
            sleep_limit = {4'h0, SLEEP_PERIODS_ZERO};
        end else begin
            sleep_limit = 16'(sleep_code) * 16'(SLEEP_PERIODS_PER_COUNT);
        end
        wake_now = |axis_hit;
        ff_now = i_mag_total < ff_limit;
        irq_clear = i_reg_rd && (i_reg_addr == ADDR_IRQ_SRC);
    end

    // configuration registers; status addresses ignore writes
    always_comb begin
        dur_d = dur_q;
        ff_d = ff_q;
        wths_d = wths_q;
        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_WAKE_SLEEP_ENTRY_TIME: dur_d = i_reg_wdata;
                ADDR_FREEFALL_CFG: ff_d = i_reg_wdata;
                ADDR_WAKE_UP_THS: wths_d = {1'b0, i_reg_wdata[6:0]};
                default: dur_d = dur_q;
            endcase
        end
    end

    // event engine, stepped once per output sample
    always_comb begin
        ff_cnt_d = ff_cnt_q;
        wk_cnt_d = wk_cnt_q;
        sl_cnt_d = sl_cnt_q;
        st_d = st_q;
        ff_event = 1'b0;
        wk_event = 1'b0;
        if (i_sample_tick) begin
            // free-fall must hold for the programmed number of samples plus one
            if (!ff_now) begin
                ff_cnt_d = 6'h00;
            end else if (ff_cnt_q < ff_time) begin
                ff_cnt_d = ff_cnt_q + ONE_6;
            end else begin
                ff_event = 1'b1;
            end
            if (!wake_now) begin
                wk_cnt_d = 2'h0;
            end else if (wk_cnt_q < wk_time) begin
                wk_cnt_d = wk_cnt_q + ONE_2;
            end else begin
                wk_event = 1'b1;
            end
            case (st_q)
                SLP_AWAKE: begin
                    // the quiet sample that starts the count is period one
                    sl_cnt_d = ONE_16;
                    if (wths_q[SLEEP_ON_BIT] && !wake_now) begin
                        st_d = SLP_COUNTING;
                    end
                end
                SLP_COUNTING: begin
                    if (!wths_q[SLEEP_ON_BIT] || wake_now) begin
                        st_d = SLP_AWAKE;
                    end else if (sl_cnt_q + ONE_16 >= sleep_limit) begin
                        st_d = SLP_ASLEEP;
                    end else begin
                        sl_cnt_d = sl_cnt_q + ONE_16;
                    end
                end
                SLP_ASLEEP: begin
                    if (wk_event || !wths_q[SLEEP_ON_BIT]) begin
                        st_d = SLP_AWAKE;
                    end
                end
                default: st_d = SLP_AWAKE;
            endcase
        end
    end

    // event flags: a new event wins over the clearing read
    always_comb begin
        ff_flag_d = ff_flag_q;
        wu_flag_d = wu_flag_q;
        axis_d = axis_q;
        or_flag_d = or_flag_q;
        slch_d = slch_q;
        if (irq_clear) begin
            ff_flag_d = 1'b0;
            wu_flag_d = 1'b0;
            axis_d = 3'h0;
            or_flag_d = 1'b0;
            slch_d = 1'b0;
        end
        if (ff_event) begin
            ff_flag_d = 1'b1;
        end
        if (wk_event) begin
            wu_flag_d = 1'b1;
            axis_d = axis_q | axis_hit;
        end
        if (i_orient_change) begin
            or_flag_d = 1'b1;
        end
        if (is_asleep(st_d) != is_asleep(st_q)) begin
            slch_d = 1'b1;
        end
        orient_d = i_orient_over;
        temp_d = i_temp_new ? 1'b1 : (i_temp_read ? 1'b0 : temp_q);
        accel_d = i_accel_new ? 1'b1 : (i_accel_read ? 1'b0 : accel_q);
        overrun_d = i_fifo_full && (i_fifo_overwrite || overrun_q);
        pend_d = ff_flag_d | wu_flag_d | or_flag_d | slch_d;
        stat_d = dur_q[STATIONARY_BIT];
        // stationary mode keeps the sample rate, so no rate switch is shown
        asleep_d = is_asleep(st_q) && !dur_q[STATIONARY_BIT];
    end

    // read data; unmapped and unused bits read zero
    always_comb begin
        case (i_reg_addr)
            ADDR_WAKE_UP_THS: rdata_d = wths_q;
            ADDR_WAKE_SLEEP_ENTRY_TIME: rdata_d = dur_q;
            ADDR_FREEFALL_CFG: rdata_d = ff_q;
            ADDR_STATUS_COPY: rdata_d = {overrun_q, temp_q, is_asleep(st_q),
                2'b00, or_flag_q, ff_flag_q, accel_q};
            ADDR_WAKEUP_SRC: rdata_d = {2'b00, ff_flag_q, is_asleep(st_q),
                wu_flag_q, axis_q};
            ADDR_ORIENT_SRC: rdata_d = {1'b0, or_flag_q, orient_q};
            ADDR_IRQ_SRC: rdata_d = {2'b00, slch_q, or_flag_q, 2'b00,
                wu_flag_q, ff_flag_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // configuration group
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            dur_q <= RESET_CFG;
            ff_q <= RESET_CFG;
            wths_q <= RESET_CFG;
        end else begin
            dur_q <= dur_d;
            ff_q <= ff_d;
            wths_q <= wths_d;
        end
    end

    // event engine group
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ff_cnt_q <= 6'h00;
            wk_cnt_q <= 2'h0;
            sl_cnt_q <= 16'h0000;
            st_q <= SLP_AWAKE;
        end else begin
            ff_cnt_q <= ff_cnt_d;
            wk_cnt_q <= wk_cnt_d;
            sl_cnt_q <= sl_cnt_d;
            st_q <= st_d;
        end
    end

    // flag and status output group
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ff_flag_q <= 1'b0;
            wu_flag_q <= 1'b0;
            axis_q <= 3'h0;
            or_flag_q <= 1'b0;
            slch_q <= 1'b0;
            orient_q <= 6'h00;
            temp_q <= 1'b0;
            accel_q <= 1'b0;
            overrun_q <= 1'b0;
            pend_q <= 1'b0;
            stat_q <= 1'b0;
            asleep_q <= 1'b0;
        end else begin
            ff_flag_q <= ff_flag_d;
            wu_flag_q <= wu_flag_d;
            axis_q <= axis_d;
            or_flag_q <= or_flag_d;
            slch_q <= slch_d;
            orient_q <= orient_d;
            temp_q <= temp_d;
            accel_q <= accel_d;
            overrun_q <= overrun_d;
            pend_q <= pend_d;
            stat_q <= stat_d;
            asleep_q <= asleep_d;
        end
    end

    // read data group
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_asleep = asleep_q;
    assign o_stationary_mode = stat_q;
    assign o_event_pending = pend_q;
endmodule : motion_event_detect_regs

// ===== test/motion_event_chk_assertions.sv
// assertion checker for the motion-event register block, bound below.
// assumes it sees only the block's own ports, one clock domain.
`timescale 1ns/1ps
module motion_event_chk (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    // sample side and status
    input wire logic i_sample_tick,
    input wire logic [5:0] i_orient_over,
    input wire logic i_orient_change,
    input wire logic i_fifo_full,
    input wire logic o_asleep,
    input wire logic o_stationary_mode,
    input wire logic o_event_pending
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    sequence cfg_wr_s;
        i_reg_wr && i_reg_addr == 8'h35;
    endsequence
    sequence cfg_rd_s;
        !i_reg_wr && i_reg_addr == 8'h35;
    endsequence
    // only a quiet acknowledge: a new event at that edge would win
    sequence ack_s;
        i_reg_rd && i_reg_addr == 8'h3b && !i_orient_change &&
            !i_sample_tick;
    endsequence
    AST_CFG_KEEP: assert property (cfg_wr_s ##1 cfg_rd_s |=>
        o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("config byte not read back");
    AST_ACK_CLEAR: assert property (ack_s |=> !o_event_pending)
        else $error("events pending after acknowledge");
    AST_PEND_SET: assert property (
        i_orient_change |-> ##[1:3] o_event_pending)
        else $error("orientation change not pending");
    AST_STAT_SLEEP: assert property (o_stationary_mode |-> !o_asleep)
        else $error("rate change while stationary mode");
    AST_UNMAPPED: assert property (i_reg_addr > 8'h3b |=>
        o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_STAT_PAD: assert property (i_reg_addr == 8'h37 |=>
        o_reg_rdata[4:3] == 2'b00)
        else $error("status unused bits set");
    AST_WAKE_PAD: assert property (i_reg_addr == 8'h38 |=>
        o_reg_rdata[7:6] == 2'b00)
        else $error("wake source unused bits set");
    AST_IRQ_PAD: assert property (i_reg_addr == 8'h3b |=>
        o_reg_rdata[7:6] == 2'b00 && o_reg_rdata[3:2] == 2'b00)
        else $error("combined source unused bits set");
    AST_ORIENT: assert property (i_reg_addr == 8'h3a &&
        $stable(i_orient_over) && !$past(i_reset) |=>
        o_reg_rdata[5:0] == $past(i_orient_over) && !o_reg_rdata[7])
        else $error("orientation bits wrong");
    AST_OVR_FULL: assert property (i_reg_addr == 8'h37 &&
        !i_fifo_full && !$past(i_fifo_full) |=> !o_reg_rdata[7])
        else $error("overrun set while not full");
endmodule : motion_event_chk

bind motion_event_detect_regs motion_event_chk u_chk (.i_clk_sys, .i_reset,
    .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
    .i_sample_tick, .i_orient_over, .i_orient_change, .i_fifo_full, .o_asleep,
    .o_stationary_mode, .o_event_pending);

// ===== test/host_model.sv
// host-side register master for the motion-event block.
// assumes the bench calls its tasks; signals change at rising edges.
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic i_clk_sys,
    // register port
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    initial begin
        {o_addr, o_wr, o_rd, o_wdata} = 18'h0;
    end
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
        @(posedge i_clk_sys);
        // data no longer valid: show the inverse, not a stale copy
        {o_wdata, o_wr} <= {~d, 1'b0};
    endtask : write
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        {o_addr, o_rd} <= {a, 1'b1};
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        // data was registered at the edge above; take it before it moves on
        @(posedge i_clk_sys);
        d = i_rdata;
    endtask : read
endmodule : host_model

// ===== test/tb_motion_event_detect_regs.sv
// self-checking bench for the motion-event register block.
// assumes host_model drives the register port; inputs change on edges.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    num_errors++; $display("BAD %0t %h %h", $time, g, e); end end
module tb_motion_event_detect_regs;
    logic i_clk_sys;
    logic i_reset;
    logic [7:0] addr, wdata, rdata, r, v;
    logic wr, rd, tick, ochg, tnew, tread, anew, aread, full, owr;
    logic [5:0] mx, my, mz, over;
    logic [4:0] total;
    logic asleep, stat, pend;
    logic [31:0] seed = 32'h34a7;
    int num_errors = 0;
    int n_compared = 0;
    motion_event_detect_regs DUT (.i_clk_sys, .i_reset, .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_sample_tick(tick), .i_mag_x(mx), .i_mag_y(my),
        .i_mag_z(mz), .i_mag_total(total), .i_orient_over(over),
        .i_orient_change(ochg), .i_temp_new(tnew), .i_temp_read(tread),
        .i_accel_new(anew), .i_accel_read(aread), .i_fifo_full(full),
        .i_fifo_overwrite(owr), .o_asleep(asleep),
        .o_stationary_mode(stat), .o_event_pending(pend));
    host_model host (.i_clk_sys, .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata), .i_rdata(rdata));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [4:0] ff_lsb(input logic [2:0] c);
        logic [4:0] t [8] = '{5'h05, 5'h07, 5'h08, 5'h0a, 5'h0b, 5'h0d,
            5'h0f, 5'h10};
        return t[c];
    endfunction : ff_lsb
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge i_clk_sys) tick <= 1'b1;
            @(posedge i_clk_sys) tick <= 1'b0;
        end
    endtask : tk
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host.read(a, r);
        `CHK(r, e)
    endtask : rc
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        #500us;
        num_errors++;
        results();
    end
    initial begin
        i_reset = 1'b1;
        {tick, ochg, tnew, tread, anew, aread, full, owr} = 8'h00;
        {mx, my, mz, over} = 24'h0;
        total = 5'h1f;
        repeat (10) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        rc(8'h34, 8'h00);
        rc(8'h35, 8'h00);
        repeat (4) begin
            v = 8'(xs());
            host.write(8'h35, v);
            rc(8'h35, v);
            `CHK(stat, v[4])
            host.write(8'h36, ~v);
            rc(8'h36, ~v);
            host.write(8'h37, v);
            rc(8'h37, 8'h00);
        end
        rc(8'h3c, 8'h00);
        host.write(8'h35, 8'h00);
        host.write(8'h36, 8'h00);
        $display("test registers done");
        @(posedge i_clk_sys) {tnew, anew, owr} <= 3'b111;
        @(posedge i_clk_sys) {tnew, anew, owr} <= 3'b000;
        rc(8'h37, 8'h41);
        @(posedge i_clk_sys) {full, owr} <= 2'b11;
        @(posedge i_clk_sys) owr <= 1'b0;
        rc(8'h37, 8'hc1);
        @(posedge i_clk_sys) {tread, aread} <= 2'b11;
        @(posedge i_clk_sys) {tread, aread, full} <= 3'b000;
        rc(8'h37, 8'h00);
        $display("test ready flags done");
        v = 8'(xs());
        @(posedge i_clk_sys) {over, ochg} <= {v[5:0], 1'b1};
        @(posedge i_clk_sys) ochg <= 1'b0;
        rc(8'h3a, {2'b01, v[5:0]});
        `CHK(pend, 1'b1)
        rc(8'h37, 8'h04);
        rc(8'h3b, 8'h10);
        rc(8'h3b, 8'h00);
        `CHK(pend, 1'b0)
        $display("test orientation done");
        // one below and exactly at each decoded threshold
        for (int c = 0; c < 8; c++) begin
            host.write(8'h36, 8'(c));
            total <= ff_lsb(3'(c)) - 5'h01;
            tk(1);
            rc(8'h38, 8'h20);
            rc(8'h37, 8'h02);
            rc(8'h3b, 8'h01);
            total <= ff_lsb(3'(c));
            tk(1);
            rc(8'h3b, 8'h00);
        end
        host.write(8'h36, 8'h00);
        host.write(8'h35, 8'h80);
        total <= 5'h00;
        tk(32);
        rc(8'h3b, 8'h00);
        tk(1);
        rc(8'h3b, 8'h01);
        `CHK(asleep, 1'b0)
        total <= 5'h1f;
        $display("test free-fall done");
        // the other axes sit exactly at the threshold, which must not wake
        host.write(8'h34, 8'h0a);
        for (int a = 0; a < 3; a++) begin
            {mx, my, mz} <= {3{6'h0a}} | (18'h1 << (6 * (2 - a)));
            tk(1);
            rc(8'h38, 8'h08 | (8'h04 >> a));
            rc(8'h3b, 8'h02);
        end
        {mx, my, mz} <= 18'h0;
        host.write(8'h35, 8'h40);
        mz <= 6'h0b;
        tk(2);
        rc(8'h38, 8'h00);
        tk(1);
        rc(8'h3b, 8'h02);
        mz <= 6'h00;
        $display("test wakeup done");
        host.write(8'h35, 8'h00);
        host.write(8'h34, 8'h40);
        tk(15);
        rc(8'h37, 8'h00);
        tk(1);
        rc(8'h37, 8'h20);
        rc(8'h38, 8'h10);
        `CHK(asleep, 1'b1)
        rc(8'h3b, 8'h20);
        host.write(8'h35, 8'h10);
        rc(8'h38, 8'h10);
        `CHK(asleep, 1'b0)
        mx <= 6'h01;
        tk(1);
        rc(8'h3b, 8'h22);
        rc(8'h37, 8'h00);
        mx <= 6'h00;
        $display("test sleep done");
        // reset in mid-run must bring back every default
        @(posedge i_clk_sys) i_reset <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        rc(8'h34, 8'h00);
        rc(8'h35, 8'h00);
        `CHK(stat, 1'b0)
        rc(8'h3b, 8'h00);
        $display("test reset done");
        results();
    end
endmodule : tb_motion_event_detect_regs
